// file: rtl/stc_regs.svh
`ifndef STC_REGS_SVH
`define STC_REGS_SVH
// Overview of operation
// - Host writes service request mask 0..255; mask bit 6 is never stored.
// - Status bit 6 is the OR of all status bits enabled by the mask.
// - MSS survives a status query; it drops only when enabled causes vanish.
// - Status byte: 7 oper, 6 MSS/RQS, 5 event, 4 message, 3 quest, 2 error.
// - Mask query returns the current mask unchanged.
// - Status query returns the byte with MSS in bit 6, changing nothing.
// - Serial poll returns the byte with RQS in bit 6, then clears RQS.
// - Armed trigger loads preset trigger levels as setpoints, then disarms.
// - With continuous triggering on, each accepted trigger re-arms at once.
// - Trigger command and group trigger act only while addressed as listener.
// - Self-test answers 0 if all modules pass, else each failing address plus one.
// - Self-test: off/open, max positive, zero, swap negative, max negative, zero/restore.
// - Modules without relays see the self-test levels directly on their output.
// - Module error reports over the module bus update that module's flags.
// - A module passes self-test when its questionable flags are all zero.
// - Wait command stalls later commands until pending work has finished.
// - With continuous off, initiate arms exactly one trigger.
// - Reset command turns continuous triggering off.
`define SRE_WMASK   8'hBF
`define SRE_RST     8'h00
`define STB_MSS     6
`define CMD_SRE     4'h1
`define CMD_SRE_Q   4'h2
`define CMD_STB_Q   4'h3
`define CMD_TRG     4'h4
`define CMD_INIT    4'h5
`define CMD_CONT    4'h6
`define CMD_RST     4'h7
`define CMD_TST     4'h8
`define CMD_WAI     4'h9
`define LVL_OFF     2'h0
`define LVL_POS     2'h1
`define LVL_ZERO    2'h2
`define LVL_NEG     2'h3
`define CLK_MHZ     10
`define ST_DWELL_US 50
`define ST_DWELL_CYC (`ST_DWELL_US * `CLK_MHZ)
`define NMOD        4
`endif

// file: rtl/stc_pkg.sv
package stc_pkg;
  typedef enum logic [1:0] {CS_IDLE, CS_WAIT, CS_TEST, CS_REPORT} ctl_state_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_OFF, ST_POS, ST_ZERO1, ST_SWAP, ST_NEG, ST_ZERO2
  } st_step_t;
endpackage

// file: rtl/selftest_seq.sv
`timescale 1ns/1ps
`include "stc_regs.svh"
module selftest_seq import stc_pkg::*; (
  input  wire logic       core_clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       ce_in,
  input  wire logic       start_in,
  input  wire logic [3:0] has_relay_in,
  output logic      [1:0] level_out,
  output logic      [3:0] relay_open_out,
  output logic      [3:0] relay_neg_out,
  output logic            meas_out,
  output logic            done_out
);
  localparam logic [9:0] DWELL_LAST = 10'(`ST_DWELL_CYC - 1);
  st_step_t   step_reg, step_next;
  logic [9:0] cnt_reg;
  logic       last;

  // Fixed step order, ending back in idle
  function automatic st_step_t step_after(input st_step_t s);
    case (s)
      ST_OFF:   step_after = ST_POS;
      ST_POS:   step_after = ST_ZERO1;
      ST_ZERO1: step_after = ST_SWAP;
      ST_SWAP:  step_after = ST_NEG;
      ST_NEG:   step_after = ST_ZERO2;
      default:  step_after = ST_IDLE;
    endcase
  endfunction

  assign last = (cnt_reg == DWELL_LAST);

  // Each step dwells so the output settles; only the positive, first zero and negative steps are measured
  always_comb begin
    step_next = step_reg;
    if (step_reg == ST_IDLE) begin
      if (start_in) step_next = ST_OFF;
    end else if (last) begin
      step_next = step_after(step_reg);
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      step_reg <= ST_IDLE;
      cnt_reg  <= 10'h000;
    end else if (ce_in) begin
      step_reg <= step_next;
      cnt_reg  <= (step_reg == ST_IDLE || last) ? 10'h000 : cnt_reg + 10'h001;
    end
  end

  // Drive levels; relay-less modules see every level at their terminals
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      level_out      <= `LVL_OFF;
      relay_open_out <= 4'h0;
      relay_neg_out  <= 4'h0;
      meas_out       <= 1'b0;
      done_out       <= 1'b0;
    end else if (ce_in) begin
      case (step_next)
        ST_POS:   level_out <= `LVL_POS;
        ST_ZERO1: level_out <= `LVL_ZERO;
        ST_NEG:   level_out <= `LVL_NEG;
        ST_ZERO2: level_out <= `LVL_ZERO;
        default:  level_out <= `LVL_OFF;
      endcase
      relay_open_out <= (step_next == ST_OFF) ? has_relay_in : 4'h0;
      relay_neg_out  <= (step_next == ST_SWAP || step_next == ST_NEG)
                        ? has_relay_in : 4'h0;
      meas_out <= last && (step_reg == ST_POS || step_reg == ST_ZERO1
                           || step_reg == ST_NEG);
      done_out <= last && (step_reg == ST_ZERO2);
    end
  end

  step_order_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    ce_in && last && step_reg == ST_POS |=> step_reg == ST_ZERO1)
    else $error("self-test step order broken");
  no_relay_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (relay_open_out | relay_neg_out) == ((relay_open_out | relay_neg_out)
    & has_relay_in))
    else $error("relay driven on relay-less module");
endmodule

// file: rtl/status_trigger_selftest_ctrl.sv
`timescale 1ns/1ps
`include "stc_regs.svh"
module status_trigger_selftest_ctrl import stc_pkg::*; (
  input  wire logic        core_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        ce_in,
  input  wire logic        cmd_valid_in,
  input  wire logic [3:0]  cmd_code_in,
  input  wire logic [7:0]  cmd_data_in,
  output logic             cmd_ready_out,
  input  wire logic        listener_in,
  input  wire logic        get_in,
  input  wire logic        spoll_in,
  output logic      [7:0]  spoll_data_out,
  output logic             resp_valid_out,
  output logic      [7:0]  resp_data_out,
  output logic             resp_last_out,
  input  wire logic        oper_sum_in,
  input  wire logic        esb_in,
  input  wire logic        mav_in,
  input  wire logic        ques_sum_in,
  input  wire logic        errq_in,
  input  wire logic        pending_in,
  input  wire logic [15:0] trig_volt_in,
  input  wire logic [15:0] trig_curr_in,
  output logic      [15:0] volt_set_out,
  output logic      [15:0] curr_set_out,
  output logic             wtg_out,
  output logic             cont_out,
  input  wire logic [3:0]  has_relay_in,
  input  wire logic        mod_err_valid_in,
  input  wire logic [1:0]  mod_err_addr_in,
  input  wire logic [7:0]  mod_err_flags_in,
  input  wire logic [3:0]  ques_clr_in,
  output logic      [3:0]  ques_nz_out,
  output logic      [1:0]  st_level_out,
  output logic      [3:0]  relay_open_out,
  output logic      [3:0]  relay_neg_out,
  output logic             meas_out,
  output logic             st_active_out
);
  // ********************************************************
  // Declarations and helpers
  // ********************************************************
  ctl_state_t  state_reg;
  logic [7:0]  sre_reg;
  logic        rqs_reg;
  logic        mss_prev_reg;
  logic        wtg_reg;
  logic        cont_reg;
  logic [7:0]  ques_reg [`NMOD];
  logic [3:0]  fail_reg;
  logic [7:0]  stb_w;
  logic        mss_w;
  logic        take;
  logic        trg_evt;
  logic        st_done;
  logic [1:0]  fail_idx;
  logic [3:0]  fail_left;

  // Status byte with a chosen bit 6; low two bits always zero
  function automatic logic [7:0] stb_build(input logic b6, input logic op,
                                            input logic es, input logic mv,
                                            input logic qs, input logic eq);
    stb_build = {op, b6, es, mv, qs, eq, 2'b00};
  endfunction

  // Lowest set bit of the failing-module mask
  function automatic logic [1:0] low_idx(input logic [3:0] m);
    low_idx = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (m[i]) low_idx = 2'(i);
    end
  endfunction

  // ********************************************************
  // Status byte summary
  // ********************************************************
  // Bit 6 of the enable mask is never set, so bit 6 cannot feed itself
  assign stb_w = stb_build(1'b0, oper_sum_in, esb_in, mav_in, ques_sum_in, errq_in);
  assign mss_w = |(stb_w & sre_reg);

  // Command handshake: stalls while waiting or running the self-test
  assign cmd_ready_out = (state_reg == CS_IDLE);
  assign take          = ce_in && cmd_valid_in && cmd_ready_out;

  // Trigger only counts while addressed as a listener
  assign trg_evt = ce_in && listener_in
                   && ((take && cmd_code_in == `CMD_TRG) || get_in);

  // ********************************************************
  // Service request mask
  // ********************************************************
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sre_reg <= `SRE_RST;
    end else if (take && cmd_code_in == `CMD_SRE) begin
      sre_reg <= cmd_data_in & `SRE_WMASK;
    end
  end

  // ********************************************************
  // Request for service and serial poll
  // ********************************************************
  // A new reason raises RQS; a poll in the same cycle loses to it
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rqs_reg        <= 1'b0;
      mss_prev_reg   <= 1'b0;
      spoll_data_out <= 8'h00;
    end else if (ce_in) begin
      mss_prev_reg <= mss_w;
      if (mss_w && !mss_prev_reg) begin
        rqs_reg <= 1'b1;
      end else if (spoll_in) begin
        rqs_reg <= 1'b0;
      end
      if (spoll_in) begin
        spoll_data_out <= stb_build(rqs_reg, oper_sum_in, esb_in, mav_in,
                                    ques_sum_in, errq_in);
      end
    end
  end

  // ********************************************************
  // Trigger system
  // ********************************************************
  // Reset outranks everything; arming commands outrank a trigger
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wtg_reg  <= 1'b0;
      cont_reg <= 1'b0;
    end else if (ce_in) begin
      if (take && cmd_code_in == `CMD_RST) begin
        cont_reg <= 1'b0;
        wtg_reg  <= 1'b0;
      end else if (take && cmd_code_in == `CMD_CONT) begin
        cont_reg <= cmd_data_in[0];
        wtg_reg  <= cmd_data_in[0] | wtg_reg;
      end else if (take && cmd_code_in == `CMD_INIT) begin
        wtg_reg <= 1'b1;
      end else if (trg_evt && wtg_reg) begin
        wtg_reg <= cont_reg;
      end
    end
  end

  // Setpoints follow the preset trigger levels on an armed trigger
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      volt_set_out <= 16'h0000;
      curr_set_out <= 16'h0000;
    end else if (ce_in) begin
      if (take && cmd_code_in == `CMD_RST) begin
        volt_set_out <= 16'h0000;
        curr_set_out <= 16'h0000;
      end else if (trg_evt && wtg_reg) begin
        volt_set_out <= trig_volt_in;
        curr_set_out <= trig_curr_in;
      end
    end
  end

  assign wtg_out  = wtg_reg;
  assign cont_out = cont_reg;

  // ********************************************************
  // Module questionable flags
  // ********************************************************
  // Flags accumulate until cleared; a report in the clear cycle survives
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < `NMOD; i++) ques_reg[i] <= 8'h00;
    end else if (ce_in) begin
      for (int i = 0; i < `NMOD; i++) begin
        ques_reg[i] <= (ques_clr_in[i] ? 8'h00 : ques_reg[i])
                       | ((mod_err_valid_in && mod_err_addr_in == 2'(i))
                          ? mod_err_flags_in : 8'h00);
      end
    end
  end

  always_comb begin
    for (int i = 0; i < `NMOD; i++) ques_nz_out[i] = |ques_reg[i];
  end

  // ********************************************************
  // Self-test sequencer
  // ********************************************************
  selftest_seq u_seq (
    .core_clk_in    (core_clk_in),
    .rst_b_in       (rst_b_in),
    .ce_in          (ce_in),
    .start_in       (take && cmd_code_in == `CMD_TST),
    .has_relay_in   (has_relay_in),
    .level_out      (st_level_out),
    .relay_open_out (relay_open_out),
    .relay_neg_out  (relay_neg_out),
    .meas_out       (meas_out),
    .done_out       (st_done)
  );

  assign st_active_out = (state_reg == CS_TEST);
  assign fail_idx      = low_idx(fail_reg);
  assign fail_left     = fail_reg & ~(4'h1 << fail_idx);

  // ********************************************************
  // Command sequencing
  // ********************************************************
  // Stale flags are not cleared first, so an old error fails the test
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg <= CS_IDLE;
      fail_reg  <= 4'h0;
    end else if (ce_in) begin
      case (state_reg)
        CS_IDLE: begin
          if (take && cmd_code_in == `CMD_WAI) state_reg <= CS_WAIT;
          if (take && cmd_code_in == `CMD_TST) state_reg <= CS_TEST;
        end
        CS_WAIT: begin
          if (!pending_in) state_reg <= CS_IDLE;
        end
        CS_TEST: begin
          if (st_done) begin
            state_reg <= CS_REPORT;
            fail_reg  <= ques_nz_out;
          end
        end
        CS_REPORT: begin
          fail_reg <= fail_left;
          if (fail_left == 4'h0) state_reg <= CS_IDLE;
        end
        default: state_reg <= CS_IDLE;
      endcase
    end
  end

  // ********************************************************
  // Responses
  // ********************************************************
  // One word per answer; the self-test sends one address per failure
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      resp_valid_out <= 1'b0;
      resp_data_out  <= 8'h00;
      resp_last_out  <= 1'b0;
    end else if (ce_in) begin
      resp_valid_out <= 1'b0;
      resp_last_out  <= 1'b0;
      if (take && cmd_code_in == `CMD_SRE_Q) begin
        resp_valid_out <= 1'b1;
        resp_last_out  <= 1'b1;
        resp_data_out  <= sre_reg;
      end else if (take && cmd_code_in == `CMD_STB_Q) begin
        resp_valid_out <= 1'b1;
        resp_last_out  <= 1'b1;
        resp_data_out  <= stb_build(mss_w, oper_sum_in, esb_in, mav_in,
                                    ques_sum_in, errq_in);
      end else if (state_reg == CS_REPORT) begin
        resp_valid_out <= 1'b1;
        resp_last_out  <= (fail_left == 4'h0);
        resp_data_out  <= (fail_reg == 4'h0) ? 8'h00
                          : 8'({6'h00, fail_idx} + 8'h01);
      end
    end
  end

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence sre_write_s;
    take && cmd_code_in == `CMD_SRE;
  endsequence

  sequence armed_trig_s;
    trg_evt && wtg_reg && !take;
  endsequence

  sre_bit6_a: assert property (sre_write_s |=>
    sre_reg == ($past(cmd_data_in) & 8'hBF))
    else $error("mask write wrong");

  mss_query_a: assert property (
    take && cmd_code_in == `CMD_STB_Q && mss_w |=> resp_valid_out && resp_data_out[6])
    else $error("MSS lost on status query");

  stb_low_a: assert property (
    take && cmd_code_in == `CMD_STB_Q |=> resp_data_out[1:0] == 2'b00
    && resp_data_out[7] == $past(oper_sum_in) && sre_reg == $past(sre_reg))
    else $error("status query word wrong");

  sre_query_a: assert property (
    take && cmd_code_in == `CMD_SRE_Q |=> resp_data_out == $past(sre_reg))
    else $error("mask query wrong");

  poll_clear_a: assert property (
    ce_in && spoll_in && !(mss_w && !mss_prev_reg)
    |=> !rqs_reg && spoll_data_out[6] == $past(rqs_reg))
    else $error("serial poll RQS handling wrong");

  trig_load_a: assert property (armed_trig_s |=>
    volt_set_out == $past(trig_volt_in) && wtg_reg == $past(cont_reg))
    else $error("armed trigger did not load levels");

  trig_listen_a: assert property (
    ce_in && !listener_in && !take |=> $stable(volt_set_out))
    else $error("trigger acted while not listener");

  one_shot_a: assert property (
    armed_trig_s ##0 !cont_reg ##1 (!take && ce_in) [*2] |-> !wtg_reg)
    else $error("single trigger re-armed");

  rst_cont_a: assert property (
    take && cmd_code_in == `CMD_RST |=> !cont_reg && !wtg_reg)
    else $error("reset left continuous on");

  wai_hold_a: assert property (
    state_reg == CS_WAIT && pending_in |-> !cmd_ready_out ##1 state_reg == CS_WAIT
    || !ce_in)
    else $error("wait released early");

  ques_set_a: assert property (
    ce_in && mod_err_valid_in && mod_err_flags_in != 8'h00
    |=> ques_nz_out[$past(mod_err_addr_in)])
    else $error("module error not recorded");

  tst_pass_a: assert property (
    ce_in && state_reg == CS_REPORT && fail_reg == 4'h0
    |=> resp_valid_out && resp_last_out && resp_data_out == 8'h00)
    else $error("passing self-test answer wrong");
endmodule

// file: bench/gpib_host_model.sv
`timescale 1ns/1ps
module gpib_host_model (
  input  wire logic       core_clk_in,
  input  wire logic       cmd_ready_in,
  input  wire logic       resp_valid_in,
  input  wire logic [7:0] resp_data_in,
  input  wire logic       resp_last_in,
  output logic            cmd_valid_out,
  output logic      [3:0] cmd_code_out,
  output logic      [7:0] cmd_data_out,
  output logic            listener_out,
  output logic            get_out,
  output logic            spoll_out
);
  // ****************************************
  // Host side of the command port
  // ****************************************
  logic [8:0] resp_q[$];

  // Idle bus at time zero, addressed as listener
  initial begin
    cmd_valid_out = 1'b0;
    cmd_code_out  = 4'h0;
    cmd_data_out  = 8'h00;
    listener_out  = 1'b1;
    get_out       = 1'b0;
    spoll_out     = 1'b0;
  end

  // Answer words collected with their last flag, in arrival order
  always @(posedge core_clk_in) begin
    if (resp_valid_in === 1'b1) begin
      resp_q.push_back({resp_last_in, resp_data_in});
    end
  end

  // Request held until an edge that sees ready; released data is inverted
  // so a device that samples late sees garbage, not a lucky leftover
  task automatic send(input logic [3:0] code, input logic [7:0] data);
    int n;
    n = 0;
    @(posedge core_clk_in);
    #10;
    cmd_valid_out = 1'b1;
    cmd_code_out  = code;
    cmd_data_out  = data;
    @(negedge core_clk_in);
    while (cmd_ready_in !== 1'b1 && n < 5000) begin
      n++;
      @(negedge core_clk_in);
    end
    @(posedge core_clk_in);
    #10;
    cmd_valid_out = 1'b0;
    cmd_data_out  = ~data;
  endtask

  // One-cycle bus message: 0 group trigger, 1 serial poll
  task automatic pulse(input int kind);
    @(posedge core_clk_in);
    #10;
    if (kind == 0) get_out = 1'b1;
    else spoll_out = 1'b1;
    @(posedge core_clk_in);
    #10;
    get_out   = 1'b0;
    spoll_out = 1'b0;
  endtask

  // Listener addressing changes only after an edge
  task automatic listen(input logic on);
    @(posedge core_clk_in);
    #10;
    listener_out = on;
  endtask
endmodule

// file: bench/test_status_trigger_selftest_ctrl.sv
`timescale 1ns/1ps
`include "stc_regs.svh"
module test_status_trigger_selftest_ctrl;
  // ****************************************
  // Wiring and bench state
  // ****************************************
  logic        core_clk_in, rst_b_in, cmd_valid, listener, get_p, spoll_p, pend, ce;
  logic        cmd_ready, resp_valid, resp_last, wtg, cont, meas, st_act, err_v;
  logic [3:0]  cmd_code, relay_open, relay_neg, ques_clr, ques_nz, relay;
  logic [7:0]  cmd_data, spoll_data, resp_data, err_flags;
  logic [4:0]  stat;
  logic [1:0]  err_addr, st_level;
  logic [15:0] tv, tc, volt, curr, ev;
  int          err_total, compares, mask, meas_n;
  int          fails[$];

  status_trigger_selftest_ctrl u_dut (
    .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .ce_in(ce),
    .cmd_valid_in(cmd_valid), .cmd_code_in(cmd_code), .cmd_data_in(cmd_data),
    .cmd_ready_out(cmd_ready), .listener_in(listener), .get_in(get_p),
    .spoll_in(spoll_p), .spoll_data_out(spoll_data), .resp_valid_out(resp_valid),
    .resp_data_out(resp_data), .resp_last_out(resp_last), .oper_sum_in(stat[4]),
    .esb_in(stat[3]), .mav_in(stat[2]), .ques_sum_in(stat[1]), .errq_in(stat[0]),
    .pending_in(pend), .trig_volt_in(tv), .trig_curr_in(tc), .volt_set_out(volt),
    .curr_set_out(curr), .wtg_out(wtg), .cont_out(cont), .has_relay_in(relay),
    .mod_err_valid_in(err_v), .mod_err_addr_in(err_addr),
    .mod_err_flags_in(err_flags), .ques_clr_in(ques_clr), .ques_nz_out(ques_nz),
    .st_level_out(st_level), .relay_open_out(relay_open),
    .relay_neg_out(relay_neg), .meas_out(meas), .st_active_out(st_act));

  gpib_host_model u_host (
    .core_clk_in(core_clk_in), .cmd_ready_in(cmd_ready), .resp_valid_in(resp_valid),
    .resp_data_in(resp_data), .resp_last_in(resp_last), .cmd_valid_out(cmd_valid),
    .cmd_code_out(cmd_code), .cmd_data_out(cmd_data), .listener_out(listener),
    .get_out(get_p), .spoll_out(spoll_p));

  // 10 MHz clock
  initial begin
    core_clk_in = 1'b0;
    forever #50 core_clk_in = ~core_clk_in;
  end

  // Measure strobes counted per self-test run
  always @(posedge core_clk_in) if (meas === 1'b1) meas_n++;

  // ****************************************
  // Helpers and reference model
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
    #10;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Bounded wait: self-test answers arrive some 3000 cycles late
  task automatic word(input string nm, input logic [8:0] exp);
    int n;
    n = 0;
    while (u_host.resp_q.size() == 0 && n < 4000) begin
      n++;
      @(posedge core_clk_in);
    end
    if (u_host.resp_q.size() == 0) chk(nm, {7'h00, exp}, 16'hxxxx);
    else chk(nm, {7'h00, exp}, {7'h00, u_host.resp_q.pop_front()});
    #10;
  endtask

  // Status byte with summary bit 6 built from the enabled causes
  function automatic logic [7:0] sbyte(input logic [4:0] s, input int m);
    logic [7:0] b;
    b = {s[4], 1'b0, s[3:0], 2'b00};
    b[6] = |(b & m[7:0]);
    return b;
  endfunction

  task automatic modrep(input int idx);
    err_addr  = idx[1:0];
    err_flags = 8'($urandom_range(255, 1));
    err_v     = 1'b1;
    tick(1);
    err_v     = 1'b0;
  endtask

  // Samples every step except the swap mid-dwell so a one-cycle skew cannot matter
  task automatic selftest(input int f[$]);
    int         at[5] = '{250, 750, 1250, 2250, 2750};
    logic [1:0] lv[5] = '{`LVL_OFF, `LVL_POS, `LVL_ZERO, `LVL_NEG, `LVL_ZERO};
    int         prev;
    prev   = 0;
    meas_n = 0;
    u_host.send(`CMD_TST, 8'h00);
    for (int k = 0; k < 5; k++) begin
      tick(at[k] - prev);
      prev = at[k];
      chk("level", lv[k], st_level);
      chk("rel_open", (k == 0) ? relay : 4'h0, relay_open);
      if (k < 4) chk("rel_neg", (k == 3) ? relay : 4'h0, relay_neg);
      chk("busy", 1, st_act);
    end
    if (f.size() == 0) word("pass", 9'h100);
    foreach (f[k]) word("fail_addr", {k == f.size() - 1, 8'(f[k] + 1)});
    chk("measures", 3, meas_n);
  endtask

  task automatic finish_test();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Hang guard, well beyond the two self-test runs
  initial begin
    #4000000;
    err_total++;
    finish_test();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(7410));
    rst_b_in = 1'b0;
    {pend, err_v, stat, err_addr, err_flags, ques_clr, tv, tc} = '0;
    ce    = 1'b1;
    relay = 4'($urandom);
    repeat (2) @(posedge core_clk_in);
    #10;
    rst_b_in = 1'b1;
    u_host.send(`CMD_SRE_Q, 8'h00);
    word("mask_rst", 9'h100);
    for (int i = 0; i < 6; i++) begin
      mask = (i == 0) ? 'hFF : $urandom_range(255);
      u_host.send(`CMD_SRE, mask[7:0]);
      mask = mask & `SRE_WMASK;
      u_host.send(`CMD_SRE_Q, 8'h00);
      word("mask", {1'b1, mask[7:0]});
      stat = 5'($urandom);
      repeat (2) begin
        u_host.send(`CMD_STB_Q, 8'h00);
        word("status", {1'b1, sbyte(stat, mask)});
      end
    end
    // Rising summary raises the poll request; a second poll sees it gone
    u_host.send(`CMD_SRE, 8'h20);
    stat = 5'h00;
    tick(2);
    stat = 5'h08;
    tick(2);
    u_host.pulse(1);
    tick(1);
    chk("poll_rqs", 16'h0060, spoll_data);
    u_host.pulse(1);
    tick(1);
    chk("poll_clr", 16'h0020, spoll_data);
    u_host.send(`CMD_STB_Q, 8'h00);
    word("mss_kept", 9'h160);
    stat = 5'h00;
    tick(2);
    u_host.send(`CMD_STB_Q, 8'h00);
    word("mss_gone", 9'h100);
    // Trigger arming, one-shot, listener gating, continuous re-arm
    u_host.send(`CMD_CONT, 8'h01);
    tick(2);
    chk("cont_on", 1, cont);
    u_host.send(`CMD_RST, 8'h00);
    tick(2);
    chk("cont_rst", 0, cont);
    tv = 16'($urandom);
    tc = 16'($urandom);
    u_host.send(`CMD_INIT, 8'h00);
    tick(2);
    chk("armed", 1, wtg);
    u_host.send(`CMD_TRG, 8'h00);
    tick(2);
    chk("volt", tv, volt);
    chk("curr", tc, curr);
    chk("disarm", 0, wtg);
    ev = tv;
    tv = ~tv;
    u_host.send(`CMD_TRG, 8'h00);
    tick(2);
    chk("one_shot", ev, volt);
    u_host.send(`CMD_INIT, 8'h00);
    u_host.listen(1'b0);
    u_host.pulse(0);
    u_host.send(`CMD_TRG, 8'h00);
    tick(2);
    chk("unlisted", ev, volt);
    chk("kept_arm", 1, wtg);
    u_host.listen(1'b1);
    // A group trigger while the clock enable is low must be lost
    ce = 1'b0;
    u_host.pulse(0);
    tick(2);
    chk("frozen", ev, volt);
    ce = 1'b1;
    u_host.pulse(0);
    tick(2);
    chk("get_volt", tv, volt);
    u_host.send(`CMD_CONT, 8'h01);
    tv = 16'($urandom);
    u_host.pulse(0);
    tick(2);
    chk("cont_volt", tv, volt);
    chk("rearm", 1, wtg);
    u_host.send(`CMD_CONT, 8'h00);
    // Self-test with two flagged modules, then cleared and repeated
    fails = '{0, 2};
    foreach (fails[k]) modrep(fails[k]);
    tick(1);
    chk("flags", 16'h0005, ques_nz);
    selftest(fails);
    ques_clr = 4'h5;
    tick(1);
    ques_clr = 4'h0;
    fails = {};
    relay = 4'($urandom);
    selftest(fails);
    // Wait command holds the port until pending work drains
    pend = 1'b1;
    u_host.send(`CMD_WAI, 8'h00);
    tick(20);
    chk("wait_hold", 0, cmd_ready);
    pend = 1'b0;
    tick(3);
    chk("wait_done", 1, cmd_ready);
    // Mid-run reset must bring the mask back to zero
    rst_b_in = 1'b0;
    tick(2);
    rst_b_in = 1'b1;
    u_host.send(`CMD_SRE_Q, 8'h00);
    word("mask_rst2", 9'h100);
    finish_test();
  end
endmodule
